// file: logic/lcd_instr_pkg.sv
// Notes on behaviour
// (R1) cursor-left shift decrements address counter
// (R2) cursor-right shift increments address counter
// (R3) display shift moves image, cursor follows
// (R4) bus width bit selects 8 or 4-bit
// (R5) 4-bit mode assembles two nibbles, high first
// (R6) line flag selects one or two lines
// (R7) glyph height bit selects 5x8 or 5x11
// (R8) glyph ram address set loads six bits
// (R9) display ram address set loads seven bits
// (R10) one-line display addresses span 00h to 4fh
// (R11) two-line addresses 00h-27h and 40h-67h
// (R12) status read returns busy and address
// (R13) host waits until busy reads low
// (R14) data write stores into selected ram
// (R15) write steps address counter by one
// (R16) first read without address set invalid
// (R17) later repeated reads return correct contents
// (R18) cursor shift prefetches display ram data
// (R19) read steps address counter by one
// (R20) host avoids display shift after glyph read
// (R21) read after write returns prefetched data
// (R22) step-up moves cursor right, address up
// (R23) scroll on write shifts whole display
// (R24) clear fills 20h and zeroes address
// (R25) instruction decoded by highest set bit; the code has no branch for bit 3
package lcd_instr_pkg;
   localparam int          DISP_DEPTH    = 128;
   localparam int          GLYPH_DEPTH   = 64;
   localparam logic [6:0]  ONE_LINE_LAST = 7'h4f;
   localparam logic [6:0]  LINE1_LAST    = 7'h27;
   localparam logic [6:0]  LINE2_FIRST   = 7'h40;
   localparam logic [6:0]  LINE2_LAST    = 7'h67;
   localparam logic [7:0]  SPACE_CODE    = 8'h20;
   localparam int          SHIFT_SC_BIT  = 3;
   localparam int          SHIFT_RL_BIT  = 2;
   localparam int          FN_WIDE_BIT   = 4;
   localparam int          FN_N_BIT      = 3;
   localparam int          FN_F_BIT      = 2;
   localparam int          ENTRY_ID_BIT  = 1;
   localparam int          ENTRY_SCR_BIT = 0;
   // execution times in ns
   localparam int          T_INSTR_NS    = 39000;
   localparam int          T_DATA_NS     = 43000;
   localparam int          T_CLEAR_NS    = 1530000;
   localparam int          CLK_NS        = 50;
   localparam int          INSTR_CYC     = T_INSTR_NS / CLK_NS;
   localparam int          DATA_CYC      = T_DATA_NS / CLK_NS;
   localparam int          CLEAR_CYC     = T_CLEAR_NS / CLK_NS;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_BUSY  = 3'b001,
      ST_CLEAR = 3'b010
   } state_t;
endpackage

// file: logic/char_lcd_instruction_decoder.sv
`timescale 1ns/10ps
module char_lcd_instruction_decoder #(
   parameter int CLEAR_CYCLES = lcd_instr_pkg::CLEAR_CYC
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       register_select,
   input  wire logic       read_not_write,
   input  wire logic       enable,
   input  wire logic [7:0] db_in,
   output logic      [7:0] db_out,
   output logic            db_oe,
   output logic            busy_flag,
   output logic      [6:0] address_counter,
   output logic            bus_width_select,
   output logic            two_row_flag,
   output logic            tall_glyph_select,
   output logic            address_step_up,
   output logic            scroll_on_write,
   output logic      [6:0] display_shift,
   output logic            glyph_ram_selected
);
   // ----------------------------------------------------------------
   // pin synchronisers and strobe edge
   // ----------------------------------------------------------------
   logic [1:0] sel_s_q, rw_s_q, en_s_q;
   logic [7:0] db_s1_q, db_s2_q;
   logic       en_d_q;
   logic       strobe;

   // the fill walks all 128 cells and the busy counter holds 21 bits
   if (CLEAR_CYCLES < 130 || CLEAR_CYCLES >= 2**21) begin : g_bad_clear
      $error("CLEAR_CYCLES out of range");
   end

   // every pin passes two flops before use
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_s_q <= 2'h0;
         rw_s_q  <= 2'h0;
         en_s_q  <= 2'h0;
         db_s1_q <= 8'h00;
         db_s2_q <= 8'h00;
         en_d_q  <= 1'b0;
      end else begin
         sel_s_q <= {sel_s_q[0], register_select};
         rw_s_q  <= {rw_s_q[0], read_not_write};
         en_s_q  <= {en_s_q[0], enable};
         db_s1_q <= db_in;
         db_s2_q <= db_s1_q;
         en_d_q  <= en_s_q[1];
      end
   end

   // transfer taken on falling enable, as on the real bus
   assign strobe = en_d_q & ~en_s_q[1];

   // ----------------------------------------------------------------
   // nibble assembly
   // ----------------------------------------------------------------
   logic       half_q;
   logic [3:0] hi_nib_q;
   logic       byte_ok;
   logic [7:0] byte_v;

   // 4-bit mode: first transfer is the high nibble on db7..db4
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         half_q   <= 1'b0;
         hi_nib_q <= 4'h0;
      end else if (strobe && !bus_width_select) begin
         half_q   <= ~half_q;                                    // R5
         hi_nib_q <= db_s2_q[7:4];
      end else if (bus_width_select) begin
         half_q <= 1'b0;
      end
   end

   assign byte_ok = strobe & (bus_width_select | half_q);        // R4 R5
   assign byte_v  = bus_width_select ? db_s2_q
                                     : {hi_nib_q, db_s2_q[7:4]};

   // ----------------------------------------------------------------
   // memories and address arithmetic
   // ----------------------------------------------------------------
   logic [7:0] disp_ram_q [lcd_instr_pkg::DISP_DEPTH];
   logic [7:0] glyph_ram_q [lcd_instr_pkg::GLYPH_DEPTH];
   logic [7:0] read_reg_q;
   logic [6:0] addr_up, addr_dn, addr_step;
   logic [7:0] ram_at_addr;
   logic [7:0] status_byte;

   // wrap display addresses inside the valid ranges of the line mode
   function automatic logic [6:0] dd_next(input logic [6:0] a,
                                          input logic up,
                                          input logic two);
      logic [6:0] r;
      r = a;
      if (!two) begin                                            // R10
         if (up) r = (a >= lcd_instr_pkg::ONE_LINE_LAST) ? 7'h00
                                                         : a + 7'h01;
         else    r = (a == 7'h00) ? lcd_instr_pkg::ONE_LINE_LAST
                                  : a - 7'h01;
      end else begin                                             // R11
         if (up) begin
            if (a == lcd_instr_pkg::LINE1_LAST)
               r = lcd_instr_pkg::LINE2_FIRST;
            else if (a >= lcd_instr_pkg::LINE2_LAST)
               r = 7'h00;
            else
               r = a + 7'h01;
         end else begin
            if (a == 7'h00)
               r = lcd_instr_pkg::LINE2_LAST;
            else if (a == lcd_instr_pkg::LINE2_FIRST)
               r = lcd_instr_pkg::LINE1_LAST;
            else
               r = a - 7'h01;
         end
      end
      return r;
   endfunction

   always_comb begin
      if (glyph_ram_selected) begin
         addr_up = {1'b0, address_counter[5:0] + 6'h01};
         addr_dn = {1'b0, address_counter[5:0] - 6'h01};
      end else begin
         addr_up = dd_next(address_counter, 1'b1, two_row_flag);
         addr_dn = dd_next(address_counter, 1'b0, two_row_flag);
      end
   end

   assign addr_step   = address_step_up ? addr_up : addr_dn;     // R22
   assign ram_at_addr = glyph_ram_selected ?
                        glyph_ram_q[address_counter[5:0]] :
                        disp_ram_q[address_counter];
   assign status_byte = {busy_flag, address_counter};            // R12

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   logic is_instr, is_status, is_wr, is_rd;
   assign is_instr  = byte_ok & ~sel_s_q[1] & ~rw_s_q[1];
   assign is_status = byte_ok & ~sel_s_q[1] &  rw_s_q[1];
   assign is_wr     = byte_ok &  sel_s_q[1] & ~rw_s_q[1];
   assign is_rd     = byte_ok &  sel_s_q[1] &  rw_s_q[1];

   lcd_instr_pkg::state_t st_q;
   logic [20:0] cnt_q;
   logic        accept;
   logic        prefetch_q;
   logic [6:0]  clr_idx_q;

   // while busy only status reads are served; host must poll
   assign accept = (st_q == lcd_instr_pkg::ST_IDLE);             // R13

   // ----------------------------------------------------------------
   // sequencer: busy timing and clear fill
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q      <= lcd_instr_pkg::ST_IDLE;
         cnt_q     <= 21'h0;
         clr_idx_q <= 7'h00;
      end else begin
         case (st_q)
            lcd_instr_pkg::ST_IDLE: begin
               if (is_instr && byte_v == 8'h01) begin
                  st_q      <= lcd_instr_pkg::ST_CLEAR;
                  cnt_q     <= 21'(CLEAR_CYCLES);
                  clr_idx_q <= 7'h00;
               end else if (is_instr) begin
                  st_q  <= lcd_instr_pkg::ST_BUSY;
                  cnt_q <= 21'(lcd_instr_pkg::INSTR_CYC);
               end else if (is_wr || is_rd) begin
                  st_q  <= lcd_instr_pkg::ST_BUSY;
                  cnt_q <= 21'(lcd_instr_pkg::DATA_CYC);
               end
            end
            lcd_instr_pkg::ST_BUSY, lcd_instr_pkg::ST_CLEAR: begin
               clr_idx_q <= clr_idx_q + 7'h01;
               if (cnt_q <= 21'h1) st_q <= lcd_instr_pkg::ST_IDLE;
               else cnt_q <= cnt_q - 21'h1;
            end
            default: st_q <= lcd_instr_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) busy_flag <= 1'b0;
      else busy_flag <= (st_q != lcd_instr_pkg::ST_IDLE) ||
                        (accept && (is_instr || is_wr || is_rd));
   end

   // ----------------------------------------------------------------
   // mode bits, address counter, display offset
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_width_select   <= 1'b1;
         two_row_flag       <= 1'b0;
         tall_glyph_select  <= 1'b0;
         address_step_up    <= 1'b1;
         scroll_on_write    <= 1'b0;
         address_counter    <= 7'h00;
         display_shift      <= 7'h00;
         glyph_ram_selected <= 1'b0;
         prefetch_q         <= 1'b0;
      end else begin
         prefetch_q <= 1'b0;
         if (accept && is_instr) begin
            // the highest set bit among 7..4 and 2..0 names the instruction; bit 3 has no branch
            if (byte_v[7]) begin                                 // R25
               address_counter    <= byte_v[6:0];                // R9
               glyph_ram_selected <= 1'b0;
               prefetch_q         <= 1'b1;
            end else if (byte_v[6]) begin
               address_counter    <= {1'b0, byte_v[5:0]};        // R8
               glyph_ram_selected <= 1'b1;
               prefetch_q         <= 1'b1;
            end else if (byte_v[5]) begin
               bus_width_select  <= byte_v[lcd_instr_pkg::FN_WIDE_BIT]; // R4
               two_row_flag      <= byte_v[lcd_instr_pkg::FN_N_BIT];  // R6
               tall_glyph_select <= byte_v[lcd_instr_pkg::FN_F_BIT];  // R7
            end else if (byte_v[4]) begin
               if (byte_v[lcd_instr_pkg::SHIFT_SC_BIT]) begin
                  // image moves; address stays, cursor rides along
                  if (byte_v[lcd_instr_pkg::SHIFT_RL_BIT])
                     display_shift <= display_shift + 7'h01;     // R3
                  else
                     display_shift <= display_shift - 7'h01;     // R3
               end else begin
                  if (byte_v[lcd_instr_pkg::SHIFT_RL_BIT])
                     address_counter <= addr_up;                 // R2
                  else
                     address_counter <= addr_dn;                 // R1
                  prefetch_q <= ~glyph_ram_selected;             // R18
               end
            end else if (byte_v[2]) begin
               // entry mode kept so steps have a direction
               address_step_up <= byte_v[lcd_instr_pkg::ENTRY_ID_BIT];
               scroll_on_write <= byte_v[lcd_instr_pkg::ENTRY_SCR_BIT];
            end else if (byte_v[1]) begin
               address_counter    <= 7'h00;
               display_shift      <= 7'h00;
               glyph_ram_selected <= 1'b0;
            end else if (byte_v[0]) begin
               address_counter    <= 7'h00;                      // R24
               display_shift      <= 7'h00;
               glyph_ram_selected <= 1'b0;
               address_step_up    <= 1'b1;
            end
         end else if (accept && (is_wr || is_rd)) begin
            address_counter <= addr_step;                        // R15 R19
            if (is_wr && scroll_on_write && !glyph_ram_selected) begin
               if (address_step_up)
                  display_shift <= display_shift - 7'h01;        // R23
               else
                  display_shift <= display_shift + 7'h01;        // R23
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // ram writes and clear fill
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (st_q == lcd_instr_pkg::ST_CLEAR)
         disp_ram_q[clr_idx_q] <= lcd_instr_pkg::SPACE_CODE;     // R24
      else if (accept && is_wr) begin
         if (glyph_ram_selected)
            glyph_ram_q[address_counter[5:0]] <= byte_v;         // R14
         else
            disp_ram_q[address_counter] <= byte_v;               // R14
      end
   end

   // ----------------------------------------------------------------
   // read data register: loaded by address set, cursor shift in display ram, and reads
   // ----------------------------------------------------------------
   // reads return the staged byte, then restage; a write does not
   // restage, so a read after a write sees the older byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) read_reg_q <= 8'h00;                           // R16
      else if (prefetch_q || (accept && is_rd))
         read_reg_q <= prefetch_q ? ram_at_addr                  // R18
                                  : (glyph_ram_selected ?
                                     glyph_ram_q[addr_step[5:0]] :
                                     disp_ram_q[addr_step]);     // R17 R21
   end

   // ----------------------------------------------------------------
   // bus read drive
   // ----------------------------------------------------------------
   logic [7:0] rd_byte;
   assign rd_byte = sel_s_q[1] ? read_reg_q : status_byte;

   // 4-bit reads hand out high nibble then low nibble on db7..db4
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         db_out <= 8'h00;
         db_oe  <= 1'b0;
      end else begin
         db_oe <= en_s_q[1] & rw_s_q[1];
         if (bus_width_select) db_out <= rd_byte;                // R12
         else if (!half_q) db_out <= {rd_byte[7:4], 4'h0};
         else db_out <= {rd_byte[3:0], 4'h0};
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_cursor_left: assert property (  // R1
      @(posedge clk) disable iff (!rst_n)
      accept && is_instr && byte_v[7:2] == 6'b000100 && !two_row_flag
      && !glyph_ram_selected && address_counter != 7'h00
      |=> address_counter == $past(address_counter) - 7'h01)
      else $error("cursor left did not decrement");
   a_cursor_right: assert property (  // R2
      @(posedge clk) disable iff (!rst_n)
      accept && is_instr && byte_v[7:2] == 6'b000101 && !two_row_flag
      && !glyph_ram_selected
      && address_counter < lcd_instr_pkg::ONE_LINE_LAST
      |=> address_counter == $past(address_counter) + 7'h01)
      else $error("cursor right did not increment");
   a_shift_keeps_addr: assert property (  // R3
      @(posedge clk) disable iff (!rst_n)
      accept && is_instr && byte_v[7:3] == 5'b00011
      |=> $stable(address_counter)
      && display_shift != $past(display_shift))
      else $error("display shift moved address");
   a_width_set: assert property (  // R4
      @(posedge clk) disable iff (!rst_n)
      accept && is_instr && byte_v[7:5] == 3'b001
      |=> bus_width_select == $past(byte_v[4]))
      else $error("bus width not taken");
   a_disp_addr_set: assert property (  // R9
      @(posedge clk) disable iff (!rst_n)
      accept && is_instr && byte_v[7]
      |=> address_counter == $past(byte_v[6:0]) && !glyph_ram_selected)
      else $error("display ram address not loaded");
   a_glyph_addr_set: assert property (  // R8
      @(posedge clk) disable iff (!rst_n)
      accept && is_instr && byte_v[7:6] == 2'b01
      |=> address_counter == {1'b0, $past(byte_v[5:0])}
      && glyph_ram_selected)
      else $error("glyph ram address not loaded");
   a_two_line_gap: assert property (  // R11
      @(posedge clk) disable iff (!rst_n)
      two_row_flag && !glyph_ram_selected && (address_counter > 7'h27)
      && (address_counter < 7'h40) && !(accept && is_instr)
      |-> 1'b0)
      else $error("two-line address in gap");
   a_busy_after: assert property (  // R13
      @(posedge clk) disable iff (!rst_n)
      accept && (is_wr || is_rd) |=> busy_flag [*8])
      else $error("busy not raised for access");
   a_write_step: assert property (  // R15
      @(posedge clk) disable iff (!rst_n)
      accept && is_wr |=> address_counter != $past(address_counter))
      else $error("write did not step address");
   c_nibble: cover property (@(posedge clk) byte_ok && !bus_width_select);
   c_status_busy: cover property (@(posedge clk) is_status && busy_flag);
   c_clear: cover property (@(posedge clk)
      st_q == lcd_instr_pkg::ST_CLEAR);
   c_read: cover property (@(posedge clk) accept && is_rd);
endmodule // char_lcd_instruction_decoder

// file: dv/lcd_host_model.sv
`timescale 1ns/10ps
// host processor on the parallel bus; keeps the host side of the protocol
module lcd_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] db_out,
   output logic            register_select,
   output logic            read_not_write,
   output logic            enable,
   output logic      [7:0] db_in
);
   logic four_bit = 1'b0;

   // idle bus at time zero
   initial begin
      register_select = 1'b0;
      read_not_write  = 1'b0;
      enable          = 1'b0;
      db_in           = 8'h00;
   end

   // ---------------------------------------------------------------
   // one enable strobe
   // ---------------------------------------------------------------
   // qualifiers stay put four edges past the falling enable, since the
   // device samples them only after its synchroniser delay
   task automatic strobe(input logic sel, input logic rw,
                         input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      register_select <= sel;
      read_not_write  <= rw;
      db_in           <= d;
      @(posedge clk);
      enable <= 1'b1;
      repeat (4) @(posedge clk);
      q = db_out;
      enable <= 1'b0;
      repeat (4) @(posedge clk);
      db_in <= ~d;  // released bus must not show the old byte
   endtask

   // one byte: a single strobe, or two nibbles high first
   task automatic xfer(input logic sel, input logic rw,
                       input logic [7:0] d, output logic [7:0] q);
      logic [7:0] hi;
      logic [7:0] lo;
      if (four_bit) begin
         strobe(sel, rw, {d[7:4], ~d[3:0]}, hi);
         strobe(sel, rw, {d[3:0], ~d[3:0]}, lo);
         q = {hi[7:4], lo[7:4]};
      end else
         strobe(sel, rw, d, q);
      if (!sel && !rw && d[7:5] == 3'b001)
         four_bit = ~d[4];
   endtask

   // poll busy until low; bounded so a stuck flag cannot hang the run
   task automatic wait_ready(output bit ok);
      logic [7:0] s;
      ok = 1'b0;
      for (int i = 0; i < 400 && !ok; i++) begin
         xfer(1'b0, 1'b1, 8'h00, s);
         ok = (s[7] === 1'b0);
      end
   endtask
endmodule // lcd_host_model

// file: dv/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic       clk;
   logic       rst_n;
   logic       register_select;
   logic       read_not_write;
   logic       enable;
   logic [7:0] db_in;
   logic [7:0] db_out;
   logic       db_oe;
   logic       busy_flag;
   logic [6:0] address_counter;
   logic       bus_width_select;
   logic       two_row_flag;
   logic       tall_glyph_select;
   logic       address_step_up;
   logic       scroll_on_write;
   logic [6:0] display_shift;
   logic       glyph_ram_selected;
   logic [7:0] flags;
   logic [6:0] ds;
   logic [7:0] q;
   int         oe_cnt    = 0;
   int         oe0;
   int         bad_count = 0;
   int         checked   = 0;

   // mode flags packed so one compare covers them all
   assign flags = {busy_flag, bus_width_select, two_row_flag,
                   tall_glyph_select, address_step_up, scroll_on_write,
                   glyph_ram_selected, 1'b0};

   // cycles in which the device drives the bus
   always @(posedge clk) begin
      if (db_oe) oe_cnt <= oe_cnt + 1;
   end

   // 20 MHz clock
   initial clk = 1'b0;
   always #25 clk = ~clk;

   // short clear count keeps the run brief
   char_lcd_instruction_decoder #(.CLEAR_CYCLES(200)) i_dut (
      .clk                (clk),
      .rst_n              (rst_n),
      .register_select    (register_select),
      .read_not_write     (read_not_write),
      .enable             (enable),
      .db_in              (db_in),
      .db_out             (db_out),
      .db_oe              (db_oe),
      .busy_flag          (busy_flag),
      .address_counter    (address_counter),
      .bus_width_select   (bus_width_select),
      .two_row_flag       (two_row_flag),
      .tall_glyph_select  (tall_glyph_select),
      .address_step_up    (address_step_up),
      .scroll_on_write    (scroll_on_write),
      .display_shift      (display_shift),
      .glyph_ram_selected (glyph_ram_selected)
   );

   lcd_host_model i_host (
      .clk             (clk),
      .db_out          (db_out),
      .register_select (register_select),
      .read_not_write  (read_not_write),
      .enable          (enable),
      .db_in           (db_in)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic ready();
      bit ok;
      i_host.wait_ready(ok);
      if (!ok) begin
         bad_count++;
         stop_test();
      end
   endtask

   // instruction (select low) or data write (select high), then wait idle
   task automatic put(input logic sel, input logic [7:0] d);
      i_host.xfer(sel, 1'b0, d, q);
      ready();
   endtask

   task automatic rd(input logic [7:0] exp);
      oe0 = oe_cnt;
      i_host.xfer(1'b1, 1'b1, 8'h00, q);
      check(q, exp);
      check({7'h00, oe_cnt != oe0}, 8'h01);
      ready();
   endtask

   // status read taken when idle, so the busy bit is expected low
   task automatic st(input logic [6:0] ac);
      i_host.xfer(1'b0, 1'b1, 8'h00, q);
      check(q, {1'b0, ac});
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      check(flags, 8'h48);
      check({1'b0, address_counter}, 8'h00);
      put(1'b0, 8'h3c); check(flags, 8'h78);
      put(1'b0, 8'h30); check(flags, 8'h48);
      $display("test function_set done");
      put(1'b0, 8'hc5); st(7'h45);
      put(1'b0, 8'h10); st(7'h44);
      put(1'b0, 8'h14); st(7'h45);
      ds = display_shift;
      put(1'b0, 8'h18); st(7'h45);
      check({1'b0, display_shift}, {1'b0, ds - 7'h01});
      put(1'b0, 8'hcf); put(1'b0, 8'h14); st(7'h00);
      put(1'b0, 8'h38); put(1'b0, 8'ha7);
      put(1'b0, 8'h14); st(7'h40);
      put(1'b0, 8'h30);
      $display("test shift done");
      put(1'b0, 8'h45); st(7'h05); check(flags, 8'h4a);
      put(1'b1, 8'h11); put(1'b1, 8'h22); st(7'h07);
      put(1'b0, 8'h45); rd(8'h11); rd(8'h22);
      st(7'h07);
      $display("test glyph_ram done");
      put(1'b0, 8'h80);
      put(1'b1, 8'h41); put(1'b1, 8'h42); st(7'h02);
      put(1'b0, 8'h80); rd(8'h41);
      put(1'b1, 8'h58); rd(8'h42);
      put(1'b0, 8'h80); put(1'b0, 8'h14); rd(8'h58);
      $display("test display_ram done");
      put(1'b0, 8'h04); check(flags, 8'h40);
      put(1'b0, 8'h85); put(1'b1, 8'h33); st(7'h04);
      put(1'b0, 8'h85); rd(8'h33); st(7'h04);
      put(1'b0, 8'h07); check(flags, 8'h4c);
      ds = display_shift;
      put(1'b1, 8'h34);
      check({1'b0, display_shift}, {1'b0, ds - 7'h01});
      put(1'b0, 8'h06);
      $display("test entry done");
      put(1'b0, 8'h01); st(7'h00);
      put(1'b0, 8'h80); rd(8'h20); rd(8'h20);
      $display("test clear done");
      put(1'b0, 8'h28); check(flags, 8'h28);
      put(1'b0, 8'h92); st(7'h12);
      put(1'b1, 8'h5a); put(1'b0, 8'h92); rd(8'h5a);
      put(1'b0, 8'h30); check(flags, 8'h48);
      $display("test nibble done");
      // second instruction sent while busy must be dropped
      oe0 = oe_cnt;
      i_host.xfer(1'b0, 1'b0, 8'h90, q);
      check({7'h00, busy_flag}, 8'h01);
      check(8'(oe_cnt - oe0), 8'h00);
      i_host.xfer(1'b0, 1'b0, 8'ha0, q);
      ready();
      st(7'h10);
      $display("test refuse done");
      stop_test();
   end
endmodule // testbench
